// ==== core/gradation_halftone_stage.sv ====
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
// How it works
// - Scanner and printer gamma use fixed tables, no setting changes them.
// - Grayscale output carries one of 256 levels per pixel.
// - With the disk option present, binary processing cannot be selected.
// - Binary output is black or white, only for memory copy or fax.
// - Grayscale: text/lowdens plain, mixed diffusion, photo dither, copied linewidth.
// - Binary: text threshold, mixed 2-level diffusion, photo 2-level dither.
// - Binary reduces each 8-bit pixel to one bit against a threshold.
// - Grayscale pulse width follows the pixel level from 0 to 255.
// - Grayscale pulse sits left, centre or right by pixel location; binary always centre.
// - Diffusion only in mixed mode: neighbour error added, matrix compare.
// - Separate copy and fax diffusion matrices, chosen by operation.
// - Grayscale diffusion gives 9 levels from one matrix; binary gives 2.
// - Dither only in photo mode; matrix type chosen per gradation mode.
// - Line width correction only in copied mode, thins edge pixels.
module gradation_halftone_stage
    import gradation_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [AXI_DATA_W-1:0] wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output logic                       wready,
    output logic [1:0]                 bresp,
    output logic                       bvalid,
    input  wire logic                  bready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output logic                       arready,
    output logic [AXI_DATA_W-1:0]      rdata,
    output logic [1:0]                 rresp,
    output logic                       rvalid,
    input  wire logic                  rready,
    input  wire logic                  hddPresent,
    input  wire logic                  pageStart,
    input  wire logic                  pageEnd,
    input  wire logic                  lineStart,
    input  wire logic                  pixValid,
    input  wire logic [7:0]            pixData,
    output logic                       outValid,
    output logic [7:0]                 outLevel,
    output logic                       outBit,
    output logic                       outBinary,
    output logic [1:0]                 pulsePos
);

    // Fixed gamma curves: logic constants, deliberately not writable
    function automatic logic [7:0] scanGamma(input logic [7:0] x);
        logic [7:0] d;
        d = x - SCAN_KNEE;
        if (x < SCAN_KNEE)
            scanGamma = x + (x >> 1);
        else
            scanGamma = SCAN_BASE + (d >> 1) + (d >> 2);
    endfunction

    function automatic logic [7:0] prnGamma(input logic [7:0] x);
        logic [7:0] d;
        d = x - PRN_KNEE;
        if (x < PRN_KNEE)
            prnGamma = x - (x >> 2);
        else
            prnGamma = PRN_BASE + d + (d >> 2);
    endfunction

    function automatic logic [7:0] ditherThr(input logic [1:0] kind,
                                            input logic [1:0] x,
                                            input logic [1:0] y);
        logic [3:0] b4;
        b4 = {x[0] ^ y[0], y[0], x[1] ^ y[1], y[1]};
        unique case (kind)
            2'h0: ditherThr = {b4, 4'h8};
            2'h1: ditherThr = {b4[3:2], 6'h20};
            2'h2: ditherThr = {x, 6'h20};
            2'h3: ditherThr = LVL_DARK;
        endcase
    endfunction

    // Diffusion matrices, 2x2, 5-bit fractional thresholds
    function automatic logic [4:0] edThr(input logic fax,
                                        input logic [1:0] x,
                                        input logic [1:0] y);
        logic [1:0] i;
        i = {y[0], x[0]};
        if (fax)
            edThr = {i[0] ^ i[1], i[1], 3'h4};
        else
            edThr = {i, 3'h4} ^ 5'h10;
    endfunction

    function automatic logic regHit(input logic [AXI_ADDR_W-1:0] a);
        regHit = (a == OFS_CTRL) || (a == OFS_THRESH) ||
                 (a == OFS_MATRIX) || (a == OFS_STATUS);
    endfunction

    // ---------------- register file ----------------
    logic                  awHeld_ff;
    logic                  wHeld_ff;
    logic [AXI_ADDR_W-1:0] awAddr_ff;
    logic [7:0]            wByte_ff;
    logic                  wLane_ff;
    logic [5:0]            ctrl_ff;
    logic [7:0]            thresh_ff;
    logic [5:0]            matrix_ff;
    logic                  bvalid_ff;
    logic [1:0]            bresp_ff;
    logic                  rvalid_ff;
    logic [1:0]            rresp_ff;
    logic [AXI_DATA_W-1:0] rdata_ff;
    logic                  doWrite;
    logic [7:0]            statusWord;

    assign awready = !awHeld_ff && !bvalid_ff;
    assign wready  = !wHeld_ff && !bvalid_ff;
    assign arready = !rvalid_ff;
    assign doWrite = awHeld_ff && wHeld_ff && !bvalid_ff;
    assign bvalid  = bvalid_ff;
    assign bresp   = bresp_ff;
    assign rvalid  = rvalid_ff;
    assign rresp   = rresp_ff;
    assign rdata   = rdata_ff;

    always_ff @(posedge mclk) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            awAddr_ff <= '0;
        end else if (awvalid && awready) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= awaddr;
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wHeld_ff <= 1'b0;
            wByte_ff <= '0;
            wLane_ff <= 1'b0;
        end else if (wvalid && wready) begin
            wHeld_ff <= 1'b1;
            wByte_ff <= wdata[7:0];
            wLane_ff <= wstrb[0];
        end else if (doWrite) begin
            wHeld_ff <= 1'b0;
        end
    end

    // Only byte lane 0 carries register bits; other lanes are ignored
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_ff   <= CTRL_RST;
            thresh_ff <= THRESH_RST;
            matrix_ff <= MATRIX_RST;
        end else if (doWrite && wLane_ff) begin
            if (awAddr_ff == OFS_CTRL)
                ctrl_ff <= wByte_ff[5:0];
            if (awAddr_ff == OFS_THRESH)
                thresh_ff <= wByte_ff;
            if (awAddr_ff == OFS_MATRIX)
                matrix_ff <= wByte_ff[5:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (doWrite) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= regHit(awAddr_ff) ? RESP_OKAY : RESP_SLVERR;
        end else if (bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= '0;
        end else if (arvalid && arready) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= regHit(araddr) ? RESP_OKAY : RESP_SLVERR;
            unique case (araddr)
                OFS_CTRL:   rdata_ff <= {26'h0, ctrl_ff};
                OFS_THRESH: rdata_ff <= {24'h0, thresh_ff};
                OFS_MATRIX: rdata_ff <= {26'h0, matrix_ff};
                OFS_STATUS: rdata_ff <= {24'h0, statusWord};
                default:    rdata_ff <= '0;
            endcase
        end else if (rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ---------------- option strap and page latch ----------------
    logic       hddMeta_ff;
    logic       hddSync_ff;
    pageState_t pageSt_ff;
    method_t    cfgMethod_ff;
    logic       cfgFax_ff;
    logic [7:0] cfgThresh_ff;
    logic [5:0] cfgMatrix_ff;
    logic       refused_ff;
    method_t    nxt_method;
    logic       wantBin;
    logic       nxt_bin;
    origMode_t  reqMode;

    always_ff @(posedge mclk) begin
        if (rst) begin
            hddMeta_ff <= 1'b0;
            hddSync_ff <= 1'b0;
        end else begin
            hddMeta_ff <= hddPresent;
            hddSync_ff <= hddMeta_ff;
        end
    end

    assign reqMode = origMode_t'(ctrl_ff[CTL_MODE_LSB +: 3]);
    assign wantBin = ctrl_ff[CTL_BIN_BIT];
    assign nxt_bin = wantBin && !hddSync_ff &&
                     (ctrl_ff[CTL_FAX_BIT] || ctrl_ff[CTL_MEMCPY_BIT]);

    always_comb begin
        nxt_method = M_GRAY;
        unique case (reqMode)
            ORIG_TXTPHOTO: nxt_method = nxt_bin ? M_ED_BIN : M_ED_GRAY;
            ORIG_PHOTO:    nxt_method = nxt_bin ? M_DITH_BIN : M_DITH_GRAY;
            ORIG_COPIED:   nxt_method = nxt_bin ? M_THRESH : M_LINEW;
            ORIG_TEXT:     nxt_method = nxt_bin ? M_THRESH : M_GRAY;
            default:       nxt_method = nxt_bin ? M_THRESH : M_GRAY;
        endcase
    end

    // Settings frozen for the whole page so a mid-page write cannot tear it
    always_ff @(posedge mclk) begin
        if (rst) begin
            pageSt_ff    <= PG_IDLE;
            cfgMethod_ff <= M_GRAY;
            cfgFax_ff    <= 1'b0;
            cfgThresh_ff <= THRESH_RST;
            cfgMatrix_ff <= MATRIX_RST;
            refused_ff   <= 1'b0;
        end else if (pageStart) begin
            pageSt_ff    <= PG_ACTIVE;
            cfgMethod_ff <= nxt_method;
            cfgFax_ff    <= ctrl_ff[CTL_FAX_BIT];
            cfgThresh_ff <= thresh_ff;
            cfgMatrix_ff <= matrix_ff;
            refused_ff   <= wantBin && !nxt_bin;
        end else if (pageEnd) begin
            pageSt_ff    <= PG_IDLE;
        end
    end

    logic cfgBin;
    assign cfgBin = (cfgMethod_ff == M_THRESH) || (cfgMethod_ff == M_ED_BIN)
                 || (cfgMethod_ff == M_DITH_BIN);
    assign statusWord = {1'b0, refused_ff, pageSt_ff == PG_ACTIVE,
                         hddSync_ff, cfgBin, cfgMethod_ff};

    // ---------------- pixel window ----------------
    // One-pixel look-ahead; the last two pixels of a line are not emitted
    logic [7:0] prevPix_ff;
    logic [7:0] curPix_ff;
    logic [7:0] nextPix_ff;
    logic [1:0] fill_ff;
    logic [1:0] xPos_ff;
    logic [1:0] yPos_ff;
    logic       winOk;
    logic       take;

    assign take  = pixValid && pageSt_ff == PG_ACTIVE;
    assign winOk = fill_ff[1];

    always_ff @(posedge mclk) begin
        if (rst || lineStart) begin
            prevPix_ff <= LVL_WHITE;
            curPix_ff  <= LVL_WHITE;
            nextPix_ff <= LVL_WHITE;
            fill_ff    <= '0;
            xPos_ff    <= '0;
        end else if (take) begin
            prevPix_ff <= curPix_ff;
            curPix_ff  <= nextPix_ff;
            nextPix_ff <= scanGamma(pixData);
            fill_ff    <= winOk ? fill_ff : fill_ff + 2'h1;
            xPos_ff    <= winOk ? xPos_ff + 2'h1 : xPos_ff;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || pageStart)
            yPos_ff <= '0;
        else if (lineStart)
            yPos_ff <= yPos_ff + 2'h1;
    end

    // ---------------- gradation methods ----------------
    logic       prevLight;
    logic       nextLight;
    logic       curDark;
    logic [9:0] edSum;
    logic [7:0] edCorr;
    logic [3:0] edQ;
    logic [7:0] edLvl;
    logic [7:0] dThr;
    logic [9:0] dgSum;
    logic [7:0] lwLvl;
    logic [7:0] nxt_raw;
    logic       nxt_bit;
    logic [9:0] err_ff;
    pulsePos_t  nxt_pos;

    assign prevLight = prevPix_ff < LVL_DARK;
    assign nextLight = nextPix_ff < LVL_DARK;
    assign curDark   = curPix_ff >= LVL_DARK;
    assign dThr      = ditherThr(cfgBin ? cfgMatrix_ff[MTX_BDITH_LSB +: 2]
                                        : cfgMatrix_ff[MTX_GDITH_LSB +: 2],
                                 xPos_ff, yPos_ff);
    assign dgSum     = {2'h0, curPix_ff} + {2'h0, dThr} - DITH_MID;
    assign edSum     = {2'h0, curPix_ff} + err_ff;
    assign edCorr    = edSum[9] ? LVL_WHITE
                     : (edSum[8] ? LVL_BLACK : edSum[7:0]);

    always_comb begin
        edQ = {1'b0, edCorr[7:5]};
        if (edCorr[4:0] >= edThr(cfgFax_ff, xPos_ff, yPos_ff))
            edQ = edQ + 4'h1;
        edLvl = (edQ == ED_STEPS) ? LVL_BLACK : {edQ[2:0], 5'h00};
    end

    // Thin dark pixels sitting on a black/white edge along the scan line
    always_comb begin
        lwLvl = curPix_ff;
        if (curDark && (prevLight != nextLight)) begin
            unique case (cfgMatrix_ff[MTX_LINEW_LSB +: 2])
                2'h0: lwLvl = curPix_ff;
                2'h1: lwLvl = curPix_ff - (curPix_ff >> 2);
                2'h2: lwLvl = curPix_ff >> 1;
                2'h3: lwLvl = LVL_WHITE;
            endcase
        end
    end

    always_comb begin
        nxt_raw = curPix_ff;
        nxt_bit = 1'b0;
        unique case (cfgMethod_ff)
            M_THRESH:    nxt_bit = curPix_ff >= cfgThresh_ff;
            M_ED_BIN:    nxt_bit = edCorr >= {edThr(cfgFax_ff, xPos_ff,
                                                 yPos_ff), 3'h0};
            M_DITH_BIN:  nxt_bit = curPix_ff > dThr;
            M_ED_GRAY:   nxt_raw = edLvl;
            M_DITH_GRAY: nxt_raw = dgSum[9] ? LVL_WHITE
                                 : (dgSum[8] ? LVL_BLACK : dgSum[7:0]);
            M_LINEW:     nxt_raw = lwLvl;
            default:     nxt_raw = curPix_ff;
        endcase
        if (cfgBin)
            nxt_raw = nxt_bit ? LVL_BLACK : LVL_WHITE;
    end

    // Error carried along the line to the right neighbour
    always_ff @(posedge mclk) begin
        if (rst || lineStart)
            err_ff <= '0;
        else if (take && winOk)
            err_ff <= {2'h0, edCorr} -
                      {2'h0, cfgBin ? nxt_raw : edLvl};
    end

    always_comb begin
        nxt_pos = POS_CENTRE;
        if (!cfgBin && prevLight && !nextLight)
            nxt_pos = POS_RIGHT;
        else if (!cfgBin && !prevLight && nextLight)
            nxt_pos = POS_LEFT;
    end

    logic       outValid_ff;
    logic [7:0] outLevel_ff;
    logic [7:0] raw_ff;
    logic       outBit_ff;
    logic [1:0] pulsePos_ff;

    always_ff @(posedge mclk) begin
        if (rst) begin
            outValid_ff <= 1'b0;
            outLevel_ff <= LVL_WHITE;
            raw_ff      <= LVL_WHITE;
            outBit_ff   <= 1'b0;
            pulsePos_ff <= POS_CENTRE;
        end else begin
            outValid_ff <= take && winOk;
            if (take && winOk) begin
                raw_ff      <= nxt_raw;
                outLevel_ff <= cfgBin ? nxt_raw : prnGamma(nxt_raw);
                outBit_ff   <= nxt_bit;
                pulsePos_ff <= nxt_pos;
            end
        end
    end

    assign outValid  = outValid_ff;
    assign outLevel  = outLevel_ff;
    assign outBit    = outBit_ff;
    assign outBinary = cfgBin;
    assign pulsePos  = pulsePos_ff;

    AST_NO_BIN_WITH_HDD: assert property (@(posedge mclk) disable iff (rst)
        pageStart && hddSync_ff |=> !cfgBin)
        else $error("binary mode latched with disk option present");

    AST_BIN_TWO_LEVELS: assert property (@(posedge mclk) disable iff (rst)
        outValid && outBinary |-> outLevel == LVL_BLACK || outLevel == LVL_WHITE)
        else $error("binary output not black or white");

    AST_THRESHOLD: assert property (@(posedge mclk) disable iff (rst)
        take && winOk && cfgMethod_ff == M_THRESH
        |=> outBit == ($past(curPix_ff) >= $past(cfgThresh_ff)))
        else $error("threshold result wrong");

    AST_PAGE_HOLD: assert property (@(posedge mclk) disable iff (rst)
        pageSt_ff == PG_ACTIVE && !pageStart [*2] |-> $stable(cfgMethod_ff))
        else $error("method changed inside a page");

    AST_GRAY_MAP: assert property (@(posedge mclk) disable iff (rst)
        pageStart && !nxt_bin && reqMode == ORIG_PHOTO
        |=> cfgMethod_ff == M_DITH_GRAY)
        else $error("photo grayscale not dithered");

    AST_BIN_MAP: assert property (@(posedge mclk) disable iff (rst)
        pageStart && nxt_bin && reqMode == ORIG_TXTPHOTO
        |=> cfgMethod_ff == M_ED_BIN)
        else $error("mixed binary not diffused");

    AST_ED_NINE: assert property (@(posedge mclk) disable iff (rst)
        outValid && cfgMethod_ff == M_ED_GRAY
        |-> raw_ff[4:0] == 5'h00 || raw_ff == LVL_BLACK)
        else $error("diffusion level off the nine-step grid");

    AST_PULSE_RIGHT: assert property (@(posedge mclk) disable iff (rst)
        take && winOk && !cfgBin && prevLight && !nextLight
        |=> pulsePos == POS_RIGHT)
        else $error("rising edge pulse not right aligned");

    AST_GRAY_PASS: assert property (@(posedge mclk) disable iff (rst)
        take && winOk && cfgMethod_ff == M_GRAY
        |=> outLevel == prnGamma($past(curPix_ff)))
        else $error("plain grayscale level wrong");

endmodule

// ==== core/gradation_pkg.sv ====
package gradation_pkg;

    localparam int          AXI_ADDR_W     = 8;
    localparam int          AXI_DATA_W     = 32;
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_THRESH     = 8'h04;
    localparam logic [7:0]  OFS_MATRIX     = 8'h08;
    localparam logic [7:0]  OFS_STATUS     = 8'h0C;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Control register fields
    localparam int          CTL_MODE_LSB   = 0;
    localparam int          CTL_BIN_BIT    = 3;
    localparam int          CTL_FAX_BIT    = 4;
    localparam int          CTL_MEMCPY_BIT = 5;
    // Matrix select register fields
    localparam int          MTX_GDITH_LSB  = 0;
    localparam int          MTX_BDITH_LSB  = 2;
    localparam int          MTX_LINEW_LSB  = 4;
    // Status register fields
    localparam int          STS_BINACT_BIT = 3;
    localparam int          STS_HDD_BIT    = 4;
    localparam int          STS_PAGE_BIT   = 5;
    localparam int          STS_REFUSE_BIT = 6;

    localparam logic [5:0]  CTRL_RST       = 6'h00;
    localparam logic [7:0]  THRESH_RST     = 8'h80;
    localparam logic [5:0]  MATRIX_RST     = 6'h00;

    // Pixel levels and fixed gamma curve knees
    localparam logic [7:0]  LVL_WHITE      = 8'h00;
    localparam logic [7:0]  LVL_BLACK      = 8'hFF;
    localparam logic [7:0]  LVL_DARK       = 8'h80;
    localparam logic [7:0]  SCAN_KNEE      = 8'h40;
    localparam logic [7:0]  SCAN_BASE      = 8'h60;
    localparam logic [7:0]  PRN_KNEE       = 8'h80;
    localparam logic [7:0]  PRN_BASE       = 8'h60;
    localparam logic [9:0]  DITH_MID       = 10'h080;
    localparam logic [3:0]  ED_STEPS       = 4'h8;

    typedef enum logic [2:0] {
        ORIG_TEXT     = 3'h0,
        ORIG_TXTPHOTO = 3'h1,
        ORIG_PHOTO    = 3'h2,
        ORIG_COPIED   = 3'h3,
        ORIG_LOWDENS  = 3'h4
    } origMode_t;

    typedef enum logic [2:0] {
        M_GRAY      = 3'h0,
        M_THRESH    = 3'h1,
        M_ED_GRAY   = 3'h2,
        M_ED_BIN    = 3'h3,
        M_DITH_GRAY = 3'h4,
        M_DITH_BIN  = 3'h5,
        M_LINEW     = 3'h6
    } method_t;

    typedef enum logic [1:0] {
        POS_CENTRE = 2'h0,
        POS_LEFT   = 2'h1,
        POS_RIGHT  = 2'h2
    } pulsePos_t;

    typedef enum logic {
        PG_IDLE   = 1'b0,
        PG_ACTIVE = 1'b1
    } pageState_t;

endpackage

// ==== sim/gradation_halftone_stage_tb.sv ====
`timescale 1ns/10ps
module gradation_halftone_stage_tb;
    import gradation_pkg::*;
    logic mclk, rst, awvalid, wvalid, bready, arvalid, rready, hddPresent;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd32;
    logic [1:0] bresp, rresp, rr;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid;
    logic pageStart, pageEnd, lineStart, pixValid, outValid;
    logic outBit, outBinary;
    logic [7:0] pixData, outLevel;
    logic [1:0] pulsePos;
    logic [7:0] gotLvl[$];
    logic gotBit[$];
    logic [1:0] gotPos[$];
    int fail_count, total_checks, base;
    method_t gExp[5] = '{M_GRAY, M_ED_GRAY, M_DITH_GRAY, M_LINEW, M_GRAY};
    method_t bExp[5] = '{M_THRESH, M_ED_BIN, M_DITH_BIN, M_THRESH, M_THRESH};

    gradation_halftone_stage dut (.mclk(mclk), .rst(rst), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .hddPresent(hddPresent), .pageStart(pageStart),
        .pageEnd(pageEnd), .lineStart(lineStart), .pixValid(pixValid),
        .pixData(pixData), .outValid(outValid), .outLevel(outLevel),
        .outBit(outBit), .outBinary(outBinary), .pulsePos(pulsePos));
    pixel_source src (.mclk(mclk), .pageStart(pageStart),
        .pageEnd(pageEnd), .lineStart(lineStart), .pixValid(pixValid),
        .pixData(pixData));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Waits as long as the slave needs; only the watchdog ends a hang
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", RESP_OKAY, bresp);
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd32 = rdata;
        rr = rresp;
    endtask

    // Status [6:0]: refused, page, disk, binary, method
    task automatic sts(logic [6:0] exp);
        rd(OFS_STATUS);
        chk("status", {25'h0, exp}, {25'h0, rd32[6:0]});
    endtask

    always @(posedge mclk) begin
        if (outValid === 1'b1) begin
            gotLvl.push_back(outLevel);
            gotBit.push_back(outBit);
            gotPos.push_back(pulsePos);
            if (outBinary === 1'b1) chk("pulsePos", 0, pulsePos);
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge mclk);
        fail_count++;
        conclude();
    end

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, hddPresent} = 7'h40;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        rd(OFS_THRESH);
        chk("thresh", 32'h80, rd32);
        rd(8'h10);
        chk("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rr});
        wr(OFS_MATRIX, 32'h3F);
        rd(OFS_MATRIX);
        chk("matrix", 32'h3F, rd32);
        // Lane 0 disabled: the threshold must keep its value
        wstrb <= 4'h0;
        wr(OFS_THRESH, 32'h11);
        wstrb <= 4'hF;
        rd(OFS_THRESH);
        chk("strb", 32'h80, rd32);
        $display("registers done");
        for (int b = 0; b < 2; b++) begin
            for (int m = 0; m < 5; m++) begin
                wr(OFS_CTRL, m | (b << 3) | (b << 4));
                src.page(1);
                sts({2'b01, 1'b0, b[0], (b ? bExp[m] : gExp[m])});
                src.page(0);
            end
        end
        $display("method table done");
        hddPresent <= 1'b1;
        wr(OFS_CTRL, 32'h18);
        src.page(1);
        sts({4'hE, M_GRAY});
        src.page(0);
        hddPresent <= 1'b0;
        wr(OFS_CTRL, 32'h08);
        src.page(1);
        sts({4'hC, M_GRAY});
        src.page(0);
        wr(OFS_CTRL, 32'h28);
        src.page(1);
        sts({4'h5, M_THRESH});
        src.page(0);
        $display("binary grant done");
        wr(OFS_CTRL, 32'h18);
        src.page(1);
        wr(OFS_CTRL, 32'h01);
        src.line(40'h00FF00FF00, 5, 0);
        src.line(40'h00FF00FF00, 5, 1);
        sts({4'h5, M_THRESH});
        chk("outBinary", 1, outBinary);
        src.page(0);
        base = gotBit.size();
        src.line(40'h00FF00FF00, 5, 0);
        repeat (4) @(posedge mclk);
        chk("count", 6, gotBit.size());
        chk("after page", 6, base);
        for (int i = 0; i < 6; i++) begin
            chk("outBit", (i % 3) == 1, gotBit[i]);
            chk("outLevel", (i % 3) == 1 ? 8'hFF : 8'h00, gotLvl[i]);
        end
        $display("binary stream done");
        // Text then copied original; copied thins the dark edge pixels
        base = gotLvl.size();
        for (int c = 0; c < 2; c++) begin
            wr(OFS_CTRL, c ? 32'h03 : 32'h00);
            src.page(1);
            src.line(40'h0000FFFF00, 5, 0);
            repeat (2) @(posedge mclk);
            chk("grayBinary", 0, outBinary);
            for (int i = 0; i < 3; i++) begin
                chk("pos", i[1] ? 2'h1 : 2'h2, gotPos[base]);
                chk("lvl", i && !c ? 8'hE9 : 8'h00, gotLvl[base]);
                base++;
            end
            src.page(0);
        end
        wr(OFS_CTRL, 32'h01);
        src.page(1);
        src.line(40'h0000808080, 3, 0);
        repeat (2) @(posedge mclk);
        chk("edLvl", 8'h88, gotLvl[base]);
        src.page(0);
        $display("gray stream done");
        conclude();
    end
endmodule

// ==== sim/pixel_source.sv ====
`timescale 1ns/10ps
module pixel_source (
    input  wire logic       mclk,
    output logic            pageStart,
    output logic            pageEnd,
    output logic            lineStart,
    output logic            pixValid,
    output logic [7:0]      pixData
);
    initial begin
        pageStart = 1'b0;
        pageEnd = 1'b0;
        lineStart = 1'b0;
        pixValid = 1'b0;
        pixData = 8'h5A;
    end

    // One-cycle page marker: 1 opens, 0 closes
    task automatic page(input bit open);
        @(posedge mclk);
        pageStart <= open;
        pageEnd <= !open;
        @(posedge mclk);
        pageStart <= 1'b0;
        pageEnd <= 1'b0;
    endtask

    // Idle data shows the inverse so a stale sample never passes
    task automatic line(input logic [39:0] px, input int n, input bit slow);
        @(posedge mclk);
        lineStart <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            lineStart <= 1'b0;
            pixValid <= 1'b1;
            pixData <= px[8*i +: 8];
            if (slow) begin
                @(posedge mclk);
                pixValid <= 1'b0;
                pixData <= ~px[8*i +: 8];
            end
        end
        @(posedge mclk);
        pixValid <= 1'b0;
        pixData <= ~pixData;
    endtask
endmodule
